// ===== rtl/amptr_regs.sv
// Purpose: APB register bank for amplifier enable, gain, switches and offset trim
// Assumes: Compare input is synchronous to pclk
// Notes:   Answers in the access cycle; unmapped addresses read zero and raise pslverr
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module amptr_regs
   import amptr_pkg::*;
(
   // APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Analog side
   input  wire logic        amp_compare_out,
   output logic             amp_enable,
   output logic      [1:0]  gain_ratio_sel,
   output logic      [6:0]  gain_ratio,
   output logic             trim_mode_sel,
   output logic             trim_reference_sel,
   output logic      [5:0]  trim_value,
   output logic      [4:0]  switch_close_bits
);
   typedef struct packed {
      amptr_state_t st;
      logic         en;
      logic [1:0]   gain;
      logic         mode;
      logic         refsel;
      logic [5:0]   trim;
      logic [4:0]   sw;
      logic [31:0]  rdata;
      logic         err;
   } amptr_regs_t;

   amptr_regs_t s_r;
   amptr_regs_t s_nxt;
   logic        hit_ctl;
   logic        hit_trim;
   logic        hit_sw;
   logic        hit_any;
   logic        wr_lane0;
   logic [31:0] rd_mux;

   ////////////////////////////////////////////////////////////////////////
   assign hit_ctl  = (paddr == AMPTR_OFF_CONTROL);
   assign hit_trim = (paddr == AMPTR_OFF_TRIM);
   assign hit_sw   = (paddr == AMPTR_OFF_SWITCH);
   assign hit_any  = hit_ctl | hit_trim | hit_sw;
   assign wr_lane0 = psel & penable & pwrite & pstrb[0];

   // Reserved bits stay zero by construction
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctl) begin
         rd_mux[AMPTR_CMP_BIT]              = amp_compare_out;
         rd_mux[AMPTR_EN_BIT]               = s_r.en;
         rd_mux[AMPTR_GAIN_LO +: 2]         = s_r.gain;
      end else if (hit_trim) begin
         rd_mux[AMPTR_MODE_BIT]             = s_r.mode;
         rd_mux[AMPTR_REF_BIT]              = s_r.refsel;
         rd_mux[AMPTR_TRIM_W-1:0]           = s_r.trim;
      end else if (hit_sw) begin
         rd_mux[AMPTR_SW_N-1:0]             = s_r.sw;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_nxt = s_r;
      case (s_r.st)
         AMPTR_ST_IDLE: begin
            if (psel) begin
               s_nxt.st    = AMPTR_ST_ACCESS;
               s_nxt.rdata = pwrite ? 32'h0000_0000 : rd_mux;
               s_nxt.err   = ~hit_any;
            end
         end
         AMPTR_ST_ACCESS: begin
            s_nxt.st = AMPTR_ST_IDLE;
            // Write lands at the single completing edge
            if (wr_lane0 && hit_ctl) begin
               s_nxt.en   = pwdata[AMPTR_EN_BIT];
               s_nxt.gain = pwdata[AMPTR_GAIN_LO +: 2];
            end
            if (wr_lane0 && hit_trim) begin
               s_nxt.mode   = pwdata[AMPTR_MODE_BIT];
               s_nxt.refsel = pwdata[AMPTR_REF_BIT];
               s_nxt.trim   = pwdata[AMPTR_TRIM_W-1:0];
            end
            if (wr_lane0 && hit_sw) begin
               s_nxt.sw = pwdata[AMPTR_SW_N-1:0];
            end
         end
         default: s_nxt.st = AMPTR_ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r.st     <= AMPTR_ST_IDLE;
         s_r.en     <= 1'b0;
         s_r.gain   <= AMPTR_GAIN_RST;
         s_r.mode   <= 1'b0;
         s_r.refsel <= 1'b0;
         s_r.trim   <= AMPTR_TRIM_RST;
         s_r.sw     <= 5'h00;
         s_r.rdata  <= 32'h0000_0000;
         s_r.err    <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data is latched at setup, so the compare bit seen is one cycle old
   assign pready             = (s_r.st == AMPTR_ST_ACCESS);
   assign prdata             = s_r.rdata;
   assign pslverr            = pready & s_r.err;
   assign amp_enable         = s_r.en;
   assign gain_ratio_sel     = s_r.gain;
   assign trim_mode_sel      = s_r.mode;
   assign trim_reference_sel = s_r.refsel;
   assign trim_value         = s_r.trim;
   assign switch_close_bits  = s_r.sw;

   amptr_gain_dec u_gain (
      .gain_ratio_sel (s_r.gain),
      .gain_ratio     (gain_ratio)
   );

   ////////////////////////////////////////////////////////////////////////
   // Masks of implemented read bits, built from the field constants
   localparam logic [31:0] AMPTR_CTL_USED = (32'h0000_0001 << AMPTR_CMP_BIT) | (32'h0000_0001 << AMPTR_EN_BIT)
                                          | (32'h0000_0003 << AMPTR_GAIN_LO);
   localparam logic [31:0] AMPTR_SW_USED  = (32'h0000_0001 << AMPTR_SW_N) - 32'h0000_0001;

   // Completed writes, as plain booleans so that checks may negate them
   logic        wr_ctl_done;
   logic        wr_trim_done;
   logic        wr_sw_done;
   assign wr_ctl_done  = wr_lane0 & hit_ctl & pready;
   assign wr_trim_done = wr_lane0 & hit_trim & pready;
   assign wr_sw_done   = wr_lane0 & hit_sw & pready;

   sequence s_wr_ctl;
      psel && penable && pwrite && pstrb[0] && hit_ctl && pready;
   endsequence
   sequence s_wr_trim;
      psel && penable && pwrite && pstrb[0] && hit_trim && pready;
   endsequence

   property p_cmp_read;
      @(posedge pclk) disable iff (!presetn)
         (psel && !penable && !pwrite && hit_ctl) |=> (prdata[AMPTR_CMP_BIT] == $past(amp_compare_out));
   endproperty
   a_cmp_read: assert property (p_cmp_read) else $error("compare bit read wrong");

   property p_en_write;
      @(posedge pclk) disable iff (!presetn)
         s_wr_ctl |=> (amp_enable == $past(pwdata[AMPTR_EN_BIT]));
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable not written");

   property p_gain_dec;
      @(posedge pclk) disable iff (!presetn)
         (gain_ratio_sel == 2'h3) |-> (gain_ratio == AMPTR_RATIO_60);
   endproperty
   a_gain_dec: assert property (p_gain_dec) else $error("gain decode wrong");

   property p_resv_zero;
      @(posedge pclk) disable iff (!presetn)
         pready |-> (prdata[31:8] == 24'h00_0000 && !(s_r.err && prdata != 32'h0000_0000));
   endproperty
   a_resv_zero: assert property (p_resv_zero) else $error("reserved bits nonzero");

   property p_mode_write;
      @(posedge pclk) disable iff (!presetn)
         s_wr_trim |=> (trim_mode_sel == $past(pwdata[AMPTR_MODE_BIT]));
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode not written");

   property p_ref_write;
      @(posedge pclk) disable iff (!presetn)
         s_wr_trim |=> (trim_reference_sel == $past(pwdata[AMPTR_REF_BIT]));
   endproperty
   a_ref_write: assert property (p_ref_write) else $error("reference not written");

   property p_trim_hold;
      @(posedge pclk) disable iff (!presetn)
         !wr_trim_done |=> $stable(trim_value);
   endproperty
   a_trim_hold: assert property (p_trim_hold) else $error("trim changed without write");

   property p_sw_write;
      @(posedge pclk) disable iff (!presetn)
         (psel && penable && pwrite && pstrb[0] && hit_sw && pready)
            |=> (switch_close_bits == $past(pwdata[AMPTR_SW_N-1:0]));
   endproperty
   a_sw_write: assert property (p_sw_write) else $error("switches not written");

   // Setup cycles of reads; the answer stands one edge later
   sequence s_rd_ctl;
      psel && !penable && !pwrite && hit_ctl;
   endsequence
   sequence s_rd_trim;
      psel && !penable && !pwrite && hit_trim;
   endsequence
   sequence s_rd_sw;
      psel && !penable && !pwrite && hit_sw;
   endsequence

   property p_ctl_resv;
      @(posedge pclk) disable iff (!presetn)
         s_rd_ctl |=> ((prdata & ~AMPTR_CTL_USED) == 32'h0000_0000);
   endproperty
   a_ctl_resv: assert property (p_ctl_resv) else $error("control reserved bits nonzero");

   property p_sw_resv;
      @(posedge pclk) disable iff (!presetn)
         s_rd_sw |=> ((prdata & ~AMPTR_SW_USED) == 32'h0000_0000);
   endproperty
   a_sw_resv: assert property (p_sw_resv) else $error("switch reserved bits nonzero");

   property p_en_read;
      @(posedge pclk) disable iff (!presetn)
         s_rd_ctl |=> (prdata[AMPTR_EN_BIT] == $past(amp_enable));
   endproperty
   a_en_read: assert property (p_en_read) else $error("enable read wrong");

   property p_gain_read;
      @(posedge pclk) disable iff (!presetn)
         s_rd_ctl |=> (prdata[AMPTR_GAIN_LO +: 2] == $past(gain_ratio_sel));
   endproperty
   a_gain_read: assert property (p_gain_read) else $error("gain read wrong");

   property p_mode_read;
      @(posedge pclk) disable iff (!presetn)
         s_rd_trim |=> (prdata[AMPTR_MODE_BIT] == $past(trim_mode_sel));
   endproperty
   a_mode_read: assert property (p_mode_read) else $error("mode read wrong");

   property p_ref_read;
      @(posedge pclk) disable iff (!presetn)
         s_rd_trim |=> (prdata[AMPTR_REF_BIT] == $past(trim_reference_sel));
   endproperty
   a_ref_read: assert property (p_ref_read) else $error("reference read wrong");

   property p_trim_read;
      @(posedge pclk) disable iff (!presetn)
         s_rd_trim |=> (prdata[AMPTR_TRIM_W-1:0] == $past(trim_value));
   endproperty
   a_trim_read: assert property (p_trim_read) else $error("trim read wrong");

   property p_sw_read;
      @(posedge pclk) disable iff (!presetn)
         s_rd_sw |=> (prdata[AMPTR_SW_N-1:0] == $past(switch_close_bits));
   endproperty
   a_sw_read: assert property (p_sw_read) else $error("switch read wrong");

   property p_trim_write;
      @(posedge pclk) disable iff (!presetn)
         s_wr_trim |=> (trim_value == $past(pwdata[AMPTR_TRIM_W-1:0]));
   endproperty
   a_trim_write: assert property (p_trim_write) else $error("trim not written");

   property p_ctl_hold;
      @(posedge pclk) disable iff (!presetn)
         !wr_ctl_done |=> ($stable(amp_enable) && $stable(gain_ratio_sel));
   endproperty
   a_ctl_hold: assert property (p_ctl_hold) else $error("control changed without write");

   property p_mode_hold;
      @(posedge pclk) disable iff (!presetn)
         !wr_trim_done |=> ($stable(trim_mode_sel) && $stable(trim_reference_sel));
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed without write");

   property p_sw_hold;
      @(posedge pclk) disable iff (!presetn)
         !wr_sw_done |=> $stable(switch_close_bits);
   endproperty
   a_sw_hold: assert property (p_sw_hold) else $error("switches changed without write");

   // Every code, not only the top one
   property p_gain_map;
      @(posedge pclk) disable iff (!presetn)
         gain_ratio == ((gain_ratio_sel == 2'h0) ? AMPTR_RATIO_20 :
                        (gain_ratio_sel == 2'h1) ? AMPTR_RATIO_30 :
                        (gain_ratio_sel == 2'h2) ? AMPTR_RATIO_40 : AMPTR_RATIO_60);
   endproperty
   a_gain_map: assert property (p_gain_map) else $error("gain map wrong");

   property p_answer;
      @(posedge pclk) disable iff (!presetn)
         (psel && !penable) |=> pready;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer after setup");

   property p_ready_pulse;
      @(posedge pclk) disable iff (!presetn)
         pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

   property p_err_unmapped;
      @(posedge pclk) disable iff (!presetn)
         (psel && !penable && !hit_any) |=> pslverr;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not flagged");

   property p_err_mapped;
      @(posedge pclk) disable iff (!presetn)
         (psel && !penable && hit_any) |=> !pslverr;
   endproperty
   a_err_mapped: assert property (p_err_mapped) else $error("mapped access flagged");
endmodule

// ===== rtl/amptr_pkg.sv
// Purpose: Constants for the amplifier control and offset trim register bank
// Assumes: APB slave, 32-bit data, word-aligned registers
// Notes:   Functional notes below
//
// Functional notes
// - Bit 7 of amp_control reads 1 when the positive input is above the negative input, else 0.
// - Bit 6 of amp_control enables the amplifier when 1, disables it when 0, and resets to 0.
// - The gain field at bits 3:2 selects feedback ratios 20, 30, 40 and 60 for codes 00 to 11.
// - Bits 5:4 and 1:0 of amp_control and bits 7:5 of amp_switch_select read as zero.
// - Bit 7 of amp_offset_trim selects normal operation at 0 and offset calibration at 1.
// - Bit 6 of amp_offset_trim picks the inverting input as reference at 0, the non-inverting at 1.
// - Bits 5:0 of amp_offset_trim hold a read/write trim value that resets to 6'b100000.
// - Bits 4:0 of amp_switch_select close switches 4 to 0 when 1, and all reset open.
package amptr_pkg;
   localparam logic [11:0] AMPTR_OFF_CONTROL = 12'h000;
   localparam logic [11:0] AMPTR_OFF_TRIM    = 12'h004;
   localparam logic [11:0] AMPTR_OFF_SWITCH  = 12'h008;
   localparam int          AMPTR_CMP_BIT     = 7;
   localparam int          AMPTR_EN_BIT      = 6;
   localparam int          AMPTR_GAIN_LO     = 2;
   localparam int          AMPTR_MODE_BIT    = 7;
   localparam int          AMPTR_REF_BIT     = 6;
   localparam int          AMPTR_TRIM_W      = 6;
   localparam int          AMPTR_SW_N        = 5;
   localparam logic [5:0]  AMPTR_TRIM_RST    = 6'h20;
   localparam logic [1:0]  AMPTR_GAIN_RST    = 2'h0;
   localparam logic [6:0]  AMPTR_RATIO_20    = 7'h14;
   localparam logic [6:0]  AMPTR_RATIO_30    = 7'h1e;
   localparam logic [6:0]  AMPTR_RATIO_40    = 7'h28;
   localparam logic [6:0]  AMPTR_RATIO_60    = 7'h3c;
   typedef enum logic [1:0] {
      AMPTR_ST_IDLE   = 2'b01,
      AMPTR_ST_ACCESS = 2'b10
   } amptr_state_t;
endpackage

// ===== rtl/amptr_gain_dec.sv
// Purpose: Decode the gain field into a feedback ratio
// Assumes: Pure combinational
// Notes:   Ratio is an integer R2/R1 for the analog trim network
`timescale 1ns/10ps
module amptr_gain_dec
   import amptr_pkg::*;
(
   // Select
   input  wire logic [1:0] gain_ratio_sel,
   // Ratio
   output logic      [6:0] gain_ratio
);
   always_comb begin
      case (gain_ratio_sel)
         2'h0:    gain_ratio = AMPTR_RATIO_20;
         2'h1:    gain_ratio = AMPTR_RATIO_30;
         2'h2:    gain_ratio = AMPTR_RATIO_40;
         default: gain_ratio = AMPTR_RATIO_60;
      endcase
   end
endmodule

// ===== dv/test_amptr_regs.sv
// Purpose: Self-checking bench for the amplifier control and offset trim registers
// Assumes: Zero-wait APB slave, compare input sampled in the setup cycle
// Notes:   Comparator stand-in trips at trim 13 during the calibration sweep
`timescale 1ns/10ps
module test_amptr_regs
   import amptr_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0]  pstrb = 4'h0;
   logic [31:0] prdata, rdat;
   logic        pready, pslverr, rerr, cmp_force = 1'b0, cal_on = 1'b0;
   logic        amp_compare_out, amp_enable, trim_mode_sel, trim_reference_sel, first;
   logic [1:0]  gain_ratio_sel;
   logic [6:0]  gain_ratio;
   logic [5:0]  trim_value;
   logic [4:0]  switch_close_bits;
   logic [6:0]  ratio_tab [4] = '{AMPTR_RATIO_20, AMPTR_RATIO_30, AMPTR_RATIO_40, AMPTR_RATIO_60};
   int          n_fail = 0, total_checks = 0, v, v1, v2;
   always #4 pclk = ~pclk;
   // Stand-in comparator, only meaningful while the sweep runs
   assign amp_compare_out = cal_on ? (trim_value >= 6'h0d) : cmp_force;
   amptr_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .amp_compare_out(amp_compare_out), .amp_enable(amp_enable), .gain_ratio_sel(gain_ratio_sel),
      .gain_ratio(gain_ratio), .trim_mode_sel(trim_mode_sel), .trim_reference_sel(trim_reference_sel),
      .trim_value(trim_value), .switch_close_bits(switch_close_bits));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h00_0000, d}, 4'h1);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0000_0000, 4'h0);
   endtask
   task automatic settle();
      repeat (4) @(posedge pclk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge pclk);
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(AMPTR_OFF_CONTROL);
      chk("control reset", rdat, 32'h0000_0000);
      rd(AMPTR_OFF_TRIM);
      chk("trim reset", rdat, 32'h0000_0020);
      rd(AMPTR_OFF_SWITCH);
      chk("switch reset", rdat, 32'h0000_0000);
      chk("ratio reset", gain_ratio, 32'h0000_0014);
      $display("test reset done");
      wr(AMPTR_OFF_CONTROL, 8'hff);
      rd(AMPTR_OFF_CONTROL);
      chk("control rb", rdat, 32'h0000_004c);
      chk("enable on", amp_enable, 32'h0000_0001);
      cmp_force <= 1'b1;
      wr(AMPTR_OFF_CONTROL, 8'h00);
      rd(AMPTR_OFF_CONTROL);
      chk("compare high", rdat, 32'h0000_0080);
      chk("enable off", amp_enable, 32'h0000_0000);
      for (v = 0; v < 4; v++) begin
         wr(AMPTR_OFF_CONTROL, 8'(v << 2));
         @(negedge pclk);
         chk("gain sel", gain_ratio_sel, 32'(v));
         chk("gain ratio", gain_ratio, 32'(ratio_tab[v]));
      end
      $display("test control done");
      wr(AMPTR_OFF_SWITCH, 8'hff);
      rd(AMPTR_OFF_SWITCH);
      chk("switch rb", rdat, 32'h0000_001f);
      chk("switch out", switch_close_bits, 32'h0000_001f);
      wr(AMPTR_OFF_SWITCH, 8'h01);
      wr(AMPTR_OFF_TRIM, 8'h45);
      apb(1'b1, AMPTR_OFF_TRIM, 32'h0000_00ff, 4'h0);
      rd(AMPTR_OFF_TRIM);
      chk("trim rb", rdat, 32'h0000_0045);
      chk("mapped no err", rerr, 32'h0000_0000);
      chk("mode", trim_mode_sel, 32'h0000_0000);
      chk("ref", trim_reference_sel, 32'h0000_0001);
      wr(12'h00c, 8'hff);
      chk("unmapped wr err", rerr, 32'h0000_0001);
      chk("unmapped wr ignored", switch_close_bits, 32'h0000_0001);
      rd(12'h00c);
      chk("unmapped rd", rdat, 32'h0000_0000);
      $display("test trim and map done");
      cal_on <= 1'b1;
      wr(AMPTR_OFF_TRIM, 8'hc0);
      settle();
      chk("cal mode", trim_mode_sel, 32'h0000_0001);
      rd(AMPTR_OFF_CONTROL);
      first = rdat[7];
      v = 0;
      do begin
         v++;
         wr(AMPTR_OFF_TRIM, 8'(8'hc0 | v));
         settle();
         rd(AMPTR_OFF_CONTROL);
      end while (rdat[7] === first && v < 63);
      v1 = v;
      wr(AMPTR_OFF_TRIM, 8'hff);
      v = 63;
      settle();
      rd(AMPTR_OFF_CONTROL);
      first = rdat[7];
      do begin
         v--;
         wr(AMPTR_OFF_TRIM, 8'(8'hc0 | (v & 63)));
         settle();
         rd(AMPTR_OFF_CONTROL);
      end while (rdat[7] === first && v > 0);
      v2 = v;
      chk("first crossing", 32'(v1), 32'h0000_000d);
      chk("second crossing", 32'(v2), 32'h0000_000c);
      wr(AMPTR_OFF_TRIM, 8'((v1 + v2) / 2));
      @(negedge pclk);
      chk("trim final", trim_value, 32'h0000_000c);
      chk("mode normal", trim_mode_sel, 32'h0000_0000);
      $display("test calibration done");
      tally_and_finish();
   end
endmodule
